// file: core/twb_pkg.sv
// Shared constants and types of the two-wire bus interface.
// Assumes a 40 MHz reference clock and a byte-wide register port.
package twb_pkg;

  // Register byte addresses
  localparam logic [7:0] TWB_ADDR_CR0   = 8'h00;
  localparam logic [7:0] TWB_ADDR_CR1   = 8'h04;
  localparam logic [7:0] TWB_ADDR_CCR   = 8'h08;
  localparam logic [7:0] TWB_ADDR_SR    = 8'h0C;
  localparam logic [7:0] TWB_ADDR_DATA  = 8'h10;
  localparam logic [7:0] TWB_ADDR_IRQST = 8'h14;
  localparam logic [7:0] TWB_ADDR_IRQMK = 8'h18;

  // Field positions
  localparam int TWB_CR0_ICE   = 7;  // interface_enable_bit
  localparam int TWB_CR0_TOEN  = 4;  // timeout detector enable
  localparam int TWB_CR0_TOSH  = 3;  // timeout period select, 1 = short
  localparam int TWB_CCR_ACK_DATA_BIT  = 5;  // ack_data_bit
  localparam int TWB_CKS_W     = 5;  // clock_divider_select width
  localparam int TWB_SR_MST    = 7;  // master_select_bit
  localparam int TWB_SR_TRS    = 6;  // transmit_direction_bit
  localparam int TWB_SR_BUSY   = 5;
  localparam int TWB_SR_AAS    = 4;  // own address matched
  localparam int TWB_SR_LRB    = 0;  // last acknowledge bit seen
  localparam int TWB_IRQ_BYTE  = 0;
  localparam int TWB_IRQ_TOUT  = 1;
  localparam int TWB_IRQ_AL    = 2;
  localparam int TWB_IRQ_NACK  = 3;
  localparam int TWB_IRQ_AAS   = 4;
  localparam int TWB_IRQ_W     = 5;

  // Values after reset
  localparam logic [7:0] TWB_CR0_RST = 8'h00;
  localparam logic [6:0] TWB_SAR_RST = 7'h00;
  localparam logic [5:0] TWB_CCR_RST = 6'h00;

  // Timing: fastest bus clock half period (400 kHz) and derived cycles
  localparam int unsigned TWB_CLK_PERIOD_NS  = 32'h00000019;  // 25 ns
  localparam int unsigned TWB_SCL_HALF_NS    = 32'h000004E2;  // 1250 ns
  localparam int unsigned TWB_HALF_BASE_CYC  =
    (TWB_SCL_HALF_NS + TWB_CLK_PERIOD_NS - 32'h1) / TWB_CLK_PERIOD_NS;
  localparam logic [15:0] TWB_TO_SHORT_CYC   = 16'h0FFF;
  localparam int unsigned TWB_TO_LONG_CYC    = 32'h0000FFFF;

  // Bus line pair carrier
  typedef struct packed {
    logic scl;
    logic sda;
  } twb_line_t;

  typedef enum {SL_IDLE, SL_ADDR, SL_RX, SL_TX, SL_SKIP} twb_sl_state_t;
  typedef enum {M_IDLE, M_START, M_LOW, M_HIGH, M_HOLD, M_STOP} twb_m_state_t;

endpackage : twb_pkg

// file: core/twb_sync.sv
// Two-flop synchroniser for the bus line pair.
// Assumes the lines are asynchronous to the reference clock.
`timescale 1ns/1ps
module twb_sync
  import twb_pkg::*;
(
  // Clock and reset
  input  wire logic      i_ref_clk,
  input  wire logic      i_reset,
  // Lines
  input  wire twb_line_t i_async,
  output twb_line_t      o_sync
);
  twb_line_t meta_q;
  twb_line_t sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule : twb_sync

// file: core/twb_timeout.sv
// Bus clock stuck-high detector with long and short periods.
// Assumes i_run is a same-clock level: bus busy and clock line high.
`timescale 1ns/1ps
module twb_timeout
  import twb_pkg::*;
#(
  parameter int unsigned LONG_CYC = TWB_TO_LONG_CYC
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  // Control
  input  wire logic i_run,
  input  wire logic i_short,
  // Event
  output logic      o_timeout
);
  logic [15:0] cnt_q, cnt_d;
  logic        done_q, done_d;
  logic [15:0] limit;
  logic [16:0] hc_q;

  // Full 16-bit span when long, a shorter span when short
  assign limit = i_short ? TWB_TO_SHORT_CYC : LONG_CYC[15:0];

  always_comb begin
    o_timeout = i_run && !done_q && (cnt_q == limit);
    done_d    = i_run && (done_q || o_timeout);
    cnt_d     = (i_run && !done_q && !o_timeout) ? cnt_q + 16'h0001 : (i_run ? cnt_q : 16'h0000);
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q  <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  // Independent run-length counter, read only by the checks below
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) hc_q <= 17'h00000;
    else if (!i_run) hc_q <= 17'h00000;
    else if (hc_q != 17'h1FFFF) hc_q <= hc_q + 17'h00001;
  end

  property p_to_len;
    @(posedge i_ref_clk) disable iff (i_reset)
    o_timeout |-> (hc_q == {1'b0, limit});
  endproperty
  a_to_len: assert property (p_to_len) else $error("timeout fired at wrong length");

  property p_short_sooner;
    @(posedge i_ref_clk) disable iff (i_reset)
    (o_timeout && i_short) |-> (hc_q == {1'b0, TWB_TO_SHORT_CYC}) && (hc_q < 17'(LONG_CYC));
  endproperty
  a_short_sooner: assert property (p_short_sooner) else $error("short timeout not shorter");
endmodule : twb_timeout

// file: core/twb_top.sv
// Two-wire bus interface: slave receive/transmit, transmit-only master,
// clock stuck-high timeout and interrupt status.
// Assumes open-drain lines resolved outside; register port on i_ref_clk.
`timescale 1ns/1ps
// Operation
// - While busy, report timeout when the clock line stays high too long.
// - In slave receive, compare the received address with own address.
// - Period select low picks long 16-bit count, high picks short count.
// - Mid-transfer, only ack data bit may change; others reset clock circuit.
// - Clearing the interface enable bit disables the interface.
// - Arbitration loss clears the master select bit.
// - Not-acknowledge in slave transmit clears the transmit direction bit.
// - Matched address with read bit 1 sets the transmit direction bit.
// - The same events clear the three-bit bit counter field.
module twb_top
  import twb_pkg::*;
#(
  parameter int unsigned TO_LONG_CYC = TWB_TO_LONG_CYC
) (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  output logic            o_irq,
  // Bus lines, open drain: output always low, enable pulls
  input  wire twb_line_t  i_pin,
  output twb_line_t       o_pin,
  output twb_line_t       o_pin_oe
);
  twb_line_t       line_s, line_p_q;
  twb_sl_state_t   sl_q, sl_d;
  twb_m_state_t    m_q, m_d;
  logic            en_q, en_d, toen_q, toen_d, tosh_q, tosh_d;
  logic [6:0]      sar_q, sar_d;
  logic [5:0]      ccr_q, ccr_d;
  logic            mst_q, mst_d, trs_q, trs_d, busy_q, busy_d;
  logic            aas_q, aas_d, lrb_q, lrb_d;
  logic [7:0]      data_q, data_d, rx_q, rx_d, shift_q, shift_d, rdata_q, rdata_d;
  logic [2:0]      bc_q, bc_d;
  logic            ackph_q, ackph_d, ninth_q, ninth_d, txp_q, txp_d, stp_q, stp_d;
  logic            scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic [10:0]     div_q, div_d, half;
  logic [TWB_IRQ_W-1:0] ist_q, ist_d, imk_q, imk_d, ev, clr;
  logic            tick, scl_rise, scl_fall, start_c, stop_c, to_pulse, clk_rst;
  logic            addr_hit, sl_nack, arb_lost;
  logic [7:0]      rbyte;

  twb_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_async   (i_pin),
    .o_sync    (line_s)
  );

  // Stuck-high clock watch runs only while the bus is held busy
  twb_timeout #(.LONG_CYC(TO_LONG_CYC)) u_tout (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_run     (en_q && toen_q && busy_q && line_s.scl),
    .i_short   (tosh_q),
    .o_timeout (to_pulse)
  );

  // Line events from the synchronised copy only
  assign scl_rise = line_s.scl && !line_p_q.scl;
  assign scl_fall = !line_s.scl && line_p_q.scl;
  assign start_c  = line_s.scl && line_p_q.scl && line_p_q.sda && !line_s.sda;
  assign stop_c   = line_s.scl && line_p_q.scl && !line_p_q.sda && line_s.sda;
  assign rbyte    = {shift_q[6:0], line_s.sda};
  assign half     = 11'(TWB_HALF_BASE_CYC * (int'(ccr_q[TWB_CKS_W-1:0]) + 1) - 1);
  assign tick     = (div_q == half);

  // Slave and master qualifiers, shared by logic and checks
  assign addr_hit = en_q && !mst_q && !start_c && !stop_c && (sl_q == SL_ADDR) && scl_rise
                    && !ackph_q && (bc_q == 3'h7) && (rbyte[7:1] == sar_q);
  assign sl_nack  = en_q && !mst_q && !start_c && !stop_c && (sl_q == SL_TX) && scl_rise
                    && ackph_q && line_s.sda;
  assign arb_lost = en_q && mst_q && (m_q == M_HIGH) && tick && line_s.scl && !ackph_q
                    && !sda_oe_q && !line_s.sda;
  assign clk_rst  = i_wr && (i_addr == TWB_ADDR_CCR) && busy_q
                    && (i_wdata[TWB_CKS_W-1:0] != ccr_q[TWB_CKS_W-1:0]);

  // Next-state logic for registers, slave engine and master engine
  always_comb begin
    {en_d, toen_d, tosh_d, sar_d, ccr_d} = {en_q, toen_q, tosh_q, sar_q, ccr_q};
    {mst_d, trs_d, busy_d, aas_d, lrb_d} = {mst_q, trs_q, busy_q, aas_q, lrb_q};
    {data_d, rx_d, shift_d, bc_d} = {data_q, rx_q, shift_q, bc_q};
    {ackph_d, ninth_d, txp_d, stp_d} = {ackph_q, ninth_q, txp_q, stp_q};
    {scl_oe_d, sda_oe_d, sl_d, m_d} = {scl_oe_q, sda_oe_q, sl_q, m_q};
    imk_d = imk_q;
    ev    = '0;
    clr   = '0;
    div_d = tick ? 11'h000 : div_q + 11'h001;
    // Register writes
    if (i_wr) begin
      if (i_addr == TWB_ADDR_CR0) begin
        en_d   = i_wdata[TWB_CR0_ICE];
        toen_d = i_wdata[TWB_CR0_TOEN];
        tosh_d = i_wdata[TWB_CR0_TOSH];
      end else if (i_addr == TWB_ADDR_CR1) begin
        sar_d = i_wdata[7:1];
      end else if (i_addr == TWB_ADDR_CCR) begin
        ccr_d = i_wdata[5:0];
      end else if (i_addr == TWB_ADDR_SR) begin
        if (i_wdata[TWB_SR_MST] && !mst_q && !busy_q && en_q) begin
          mst_d = 1'b1; trs_d = 1'b1; m_d = M_START; div_d = 11'h000; shift_d = data_q;
        end else if (!i_wdata[TWB_SR_MST] && mst_q) begin
          stp_d = 1'b1;
        end
      end else if (i_addr == TWB_ADDR_DATA) begin
        data_d = i_wdata;
        txp_d  = mst_q;
      end else if (i_addr == TWB_ADDR_IRQST) begin
        clr = i_wdata[TWB_IRQ_W-1:0];
      end else if (i_addr == TWB_ADDR_IRQMK) begin
        imk_d = i_wdata[TWB_IRQ_W-1:0];
      end
    end
    // Slave engine, idle while this end is master
    if (!mst_q) begin
      if (start_c) begin
        sl_d = SL_ADDR; bc_d = 3'h0; ackph_d = 1'b0; ninth_d = 1'b0;
        aas_d = 1'b0; busy_d = 1'b1; sda_oe_d = 1'b0;
      end else if (stop_c) begin
        sl_d = SL_IDLE; busy_d = 1'b0; aas_d = 1'b0; sda_oe_d = 1'b0; trs_d = 1'b0;
      end else begin
        case (sl_q)
          SL_ADDR, SL_RX: begin
            if (scl_rise && !ackph_q) begin
              shift_d = rbyte;
              bc_d    = bc_q + 3'h1;
              if (bc_q == 3'h7) begin
                ackph_d = 1'b1;
                if (sl_q == SL_RX) begin
                  rx_d = rbyte; ev[TWB_IRQ_BYTE] = 1'b1;
                end else if (addr_hit) begin
                  aas_d = 1'b1;
                  trs_d = line_s.sda;
                  bc_d  = 3'h0;
                  ev[TWB_IRQ_AAS] = 1'b1;
                end else begin
                  sl_d = SL_SKIP; ackph_d = 1'b0;
                end
              end
            end else if (scl_fall && ackph_q && !ninth_q) begin
              sda_oe_d = (sl_q == SL_ADDR) || !ccr_q[TWB_CCR_ACK_DATA_BIT];
              ninth_d  = 1'b1;
            end else if (scl_fall && ninth_q) begin
              ackph_d = 1'b0; ninth_d = 1'b0; sda_oe_d = 1'b0;
              if (sl_q == SL_ADDR && trs_q) begin
                sl_d = SL_TX; shift_d = data_q; sda_oe_d = !data_q[7];
              end else begin
                sl_d = SL_RX;
              end
            end
          end
          SL_TX: begin
            if (scl_rise && !ackph_q) begin
              shift_d = {shift_q[6:0], 1'b0};
              bc_d    = bc_q + 3'h1;
              if (bc_q == 3'h7) begin
                ackph_d = 1'b1; ev[TWB_IRQ_BYTE] = 1'b1;
              end
            end else if (scl_rise && ackph_q) begin
              lrb_d = line_s.sda; ninth_d = 1'b1;
              if (sl_nack) begin  // Master ends the read: hand the line back
                trs_d = 1'b0;
                bc_d  = 3'h0;
                sl_d  = SL_SKIP; ackph_d = 1'b0; ninth_d = 1'b0;
                ev[TWB_IRQ_NACK] = 1'b1;
              end
            end else if (scl_fall && !ackph_q) begin
              sda_oe_d = !shift_q[7];
            end else if (scl_fall && !ninth_q) begin
              sda_oe_d = 1'b0;
            end else if (scl_fall) begin
              ackph_d = 1'b0; ninth_d = 1'b0; shift_d = data_q; sda_oe_d = !data_q[7];
            end
          end
          default: sda_oe_d = 1'b0;
        endcase
      end
    end else begin
      // Master engine, paced by the divider; clock stretching holds the high phase
      case (m_q)
        M_START: if (tick) begin
          if (!sda_oe_q) begin
            sda_oe_d = 1'b1; busy_d = 1'b1;
          end else begin
            scl_oe_d = 1'b1; m_d = M_LOW; bc_d = 3'h0; ackph_d = 1'b0;
          end
        end
        M_LOW: if (tick) begin
          sda_oe_d = !ackph_q && !shift_q[7];
          scl_oe_d = 1'b0;
          m_d      = M_HIGH;
        end
        M_HIGH: begin
          if (!line_s.scl) begin
            div_d = 11'h000;
          end else if (tick) begin
            scl_oe_d = 1'b1;
            m_d      = M_LOW;
            if (arb_lost) begin
              mst_d = 1'b0;
              trs_d = 1'b0;
              bc_d  = 3'h0;
              scl_oe_d = 1'b0; sda_oe_d = 1'b0; m_d = M_IDLE;
              ev[TWB_IRQ_AL] = 1'b1;
            end else if (!ackph_q) begin
              shift_d = {shift_q[6:0], 1'b0};
              bc_d    = bc_q + 3'h1;
              ackph_d = (bc_q == 3'h7);
            end else begin
              lrb_d   = line_s.sda;
              ackph_d = 1'b0;
              m_d     = M_HOLD;
              ev[TWB_IRQ_BYTE] = 1'b1;
              ev[TWB_IRQ_NACK] = line_s.sda;
            end
          end
        end
        M_HOLD: begin
          // Clock held low until software supplies the next byte or asks to stop
          div_d = 11'h000;
          if (txp_q) begin
            shift_d = data_q; txp_d = 1'b0; m_d = M_LOW;
          end else if (stp_q) begin
            sda_oe_d = 1'b1; stp_d = 1'b0; m_d = M_STOP;
          end
        end
        M_STOP: if (tick) begin
          if (scl_oe_q) begin
            scl_oe_d = 1'b0;
          end else if (line_s.scl) begin
            sda_oe_d = 1'b0; mst_d = 1'b0; trs_d = 1'b0; busy_d = 1'b0; m_d = M_IDLE;
          end
        end
        default: m_d = M_IDLE;
      endcase
    end
    // Divider rewrite mid-transfer restarts the clock circuit and drops the transfer
    if (clk_rst) begin
      div_d = 11'h000; m_d = M_IDLE; mst_d = 1'b0;
      scl_oe_d = 1'b0; sda_oe_d = 1'b0; bc_d = 3'h0; sl_d = SL_SKIP;
    end
    // Disabled interface lets go of both lines and forgets its state
    if (!en_q) begin
      sl_d = SL_IDLE; m_d = M_IDLE; mst_d = 1'b0; trs_d = 1'b0; busy_d = 1'b0;
      aas_d = 1'b0; bc_d = 3'h0; scl_oe_d = 1'b0; sda_oe_d = 1'b0;
      ackph_d = 1'b0; ninth_d = 1'b0; txp_d = 1'b0; stp_d = 1'b0;
    end
    ev[TWB_IRQ_TOUT] = to_pulse;
    // Set wins over a same-cycle clear
    ist_d = (ist_q & ~clr) | ev;
    // Read data, valid the cycle after the read strobe
    rdata_d = 8'h00;
    if (i_rd) begin
      if (i_addr == TWB_ADDR_CR0) rdata_d = {en_q, 2'h0, toen_q, tosh_q, 3'h0} | {5'h00, bc_q};
      else if (i_addr == TWB_ADDR_CR1) rdata_d = {sar_q, 1'b0};
      else if (i_addr == TWB_ADDR_CCR) rdata_d = {2'h0, ccr_q};
      else if (i_addr == TWB_ADDR_SR) rdata_d = {mst_q, trs_q, busy_q, aas_q, 3'h0, lrb_q};
      else if (i_addr == TWB_ADDR_DATA) rdata_d = rx_q;
      else if (i_addr == TWB_ADDR_IRQST) rdata_d = {3'h0, ist_q};
      else if (i_addr == TWB_ADDR_IRQMK) rdata_d = {3'h0, imk_q};
    end
  end

  // State registers
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      {en_q, toen_q, tosh_q} <= {TWB_CR0_RST[TWB_CR0_ICE], TWB_CR0_RST[TWB_CR0_TOEN], TWB_CR0_RST[TWB_CR0_TOSH]};
      sar_q <= TWB_SAR_RST;
      ccr_q <= TWB_CCR_RST;
      {mst_q, trs_q, busy_q, aas_q, lrb_q} <= 5'h00;
      {data_q, rx_q, shift_q, rdata_q} <= 32'h00000000;
      bc_q <= 3'h0;
      {ackph_q, ninth_q, txp_q, stp_q, scl_oe_q, sda_oe_q} <= 6'h00;
      sl_q <= SL_IDLE;
      m_q  <= M_IDLE;
      div_q <= 11'h000;
      ist_q <= '0;
      imk_q <= '0;
      line_p_q <= '1;
    end else begin
      {en_q, toen_q, tosh_q} <= {en_d, toen_d, tosh_d};
      sar_q <= sar_d;
      ccr_q <= ccr_d;
      {mst_q, trs_q, busy_q, aas_q, lrb_q} <= {mst_d, trs_d, busy_d, aas_d, lrb_d};
      {data_q, rx_q, shift_q, rdata_q} <= {data_d, rx_d, shift_d, rdata_d};
      bc_q <= bc_d;
      {ackph_q, ninth_q, txp_q, stp_q, scl_oe_q, sda_oe_q} <= {ackph_d, ninth_d, txp_d, stp_d, scl_oe_d, sda_oe_d};
      sl_q <= sl_d;
      m_q  <= m_d;
      div_q <= div_d;
      ist_q <= ist_d;
      imk_q <= imk_d;
      line_p_q <= line_s;
    end
  end

  // Outputs
  assign o_rdata  = rdata_q;
  assign o_irq    = |(ist_q & imk_q);
  assign o_pin    = '0;
  assign o_pin_oe = '{scl: scl_oe_q, sda: sda_oe_q};

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  property p_tout_flag;
    to_pulse |=> ist_q[TWB_IRQ_TOUT];
  endproperty
  a_tout_flag: assert property (p_tout_flag) else $error("timeout not flagged");
  property p_addr_match;
    addr_hit |=> aas_q && ist_q[TWB_IRQ_AAS] && (bc_q == 3'h0);
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("address match not shown");
  property p_rw_sets_trs;
    addr_hit |=> (trs_q == $past(line_s.sda));
  endproperty
  a_rw_sets_trs: assert property (p_rw_sets_trs) else $error("direction bit not from rw bit");
  property p_nack_trs;
    sl_nack && !clk_rst |=> !trs_q && (bc_q == 3'h0) ##1 (sl_q == SL_SKIP) || !en_q;
  endproperty
  a_nack_trs: assert property (p_nack_trs) else $error("nack did not clear direction");
  property p_arb_mst;
    arb_lost |=> !mst_q && !scl_oe_q && !sda_oe_q;
  endproperty
  a_arb_mst: assert property (p_arb_mst) else $error("arbitration loss kept master");
  property p_bc_clear;
    (addr_hit || sl_nack || arb_lost) |=> (bc_q == 3'h0);
  endproperty
  a_bc_clear: assert property (p_bc_clear) else $error("bit counter not cleared");
  property p_disable;
    !en_q |=> !scl_oe_q && !sda_oe_q && !mst_q && !busy_q;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled interface still active");
  property p_clk_rst;
    clk_rst |=> (div_q == 11'h000) && !mst_q && (m_q == M_IDLE);
  endproperty
  a_clk_rst: assert property (p_clk_rst) else $error("clock circuit not reset");
  property p_ack_only;
    (i_wr && i_addr == TWB_ADDR_CCR && busy_q && mst_q && !clk_rst) |=> mst_q || $past(arb_lost);
  endproperty
  a_ack_only: assert property (p_ack_only) else $error("ack-only write broke transfer");

  c_addr: cover property (addr_hit ##[1:400] (sl_q == SL_TX));
  c_nack: cover property (sl_nack);
  c_arb:  cover property (arb_lost);
  c_tout: cover property (to_pulse && tosh_q);
endmodule : twb_top

// file: bench/twb_peer.sv
// Behavioural far-side bus master for the two-wire bench.
// Assumes pull-ups on both lines; it only ever pulls them low.
`timescale 1ns/1ps
module twb_peer (
  // Resolved lines
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Pull enables, high = pull low
  output logic      o_scl_oe,
  output logic      o_sda_oe
);
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  // 200 ns bit; data moves 25 ns after the clock falls, never while it is high
  task automatic bit_io(input logic b, output logic r);
    #25 o_sda_oe = ~b;
    #75 o_scl_oe = 1'b0;
    #50 r = i_sda;
    #50 o_scl_oe = 1'b1;
  endtask : bit_io
  // Start, then hold the clock low
  task automatic start();
    o_sda_oe = 1'b1;
    #100 o_scl_oe = 1'b1;
  endtask : start
  // Let the clock float high, as a stuck line would
  task automatic float_clk();
    o_scl_oe = 1'b0;
  endtask : float_clk
  // Hold the data line low while the clock is left to the other master
  task automatic pull_sda();
    o_sda_oe = 1'b1;
  endtask : pull_sda
  task automatic stop();
    #25 o_sda_oe = 1'b1;
    #75 o_scl_oe = 1'b0;
    #100 o_sda_oe = 1'b0;
    #100;
  endtask : stop
  // Byte MSB first plus ninth bit; a read sends 8'hFF and ends with a nack
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, ack);
  endtask : xfer
endmodule : twb_peer

// file: bench/testbench.sv
// Self-checking bench: register port, slave link, timeout, disable.
// Assumes twb_peer as the far side and pull-ups on both lines.
`timescale 1ns/1ps
module testbench;
  import twb_pkg::*;
  localparam int unsigned TO_CYC = 6000;  // Shortened long count, still above the short one
  logic       i_ref_clk = 1'b0;
  logic       i_reset   = 1'b1;
  logic [7:0] i_addr    = 8'h00;
  logic [7:0] i_wdata   = 8'h00;
  logic       i_wr      = 1'b0;
  logic       i_rd      = 1'b0;
  logic [7:0] o_rdata;
  logic       o_irq;
  twb_line_t  i_pin, o_pin, o_pin_oe;
  logic       m_scl_oe, m_sda_oe, ack;
  logic [7:0] q;
  int         fail_count = 0;
  int         num_checks = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  // Wired-and with pull-ups: a released line reads high
  assign i_pin = '{scl: ~(o_pin_oe.scl | m_scl_oe), sda: ~(o_pin_oe.sda | m_sda_oe)};
  twb_top #(.TO_LONG_CYC(TO_CYC)) u_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_pin(i_pin),
    .o_pin(o_pin), .o_pin_oe(o_pin_oe));
  twb_peer u_peer (.i_scl(i_pin.scl), .i_sda(i_pin.sda), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
  task automatic chk(input string n, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;  // Effects of the write are only visible after the edge settles
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, m, e, input string n);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(n, e, o_rdata & m);
  endtask : rc
  task automatic t_reset();
    rc(TWB_ADDR_CR0, 8'hFF, TWB_CR0_RST, "cr0 reset");
    rc(8'h1C, 8'hFF, 8'h00, "unmapped");
    chk("irq reset", 8'h00, {7'h00, o_irq});
    wr(TWB_ADDR_CR0, 8'h90);
    rc(TWB_ADDR_CR0, 8'hF8, 8'h90, "cr0 fields");
    wr(TWB_ADDR_CR1, 8'h54);
    wr(TWB_ADDR_IRQMK, 8'h1F);
    $display("done reset");
  endtask : t_reset
  task automatic t_write();
    u_peer.start();
    u_peer.xfer(8'h54, q, ack);
    chk("addr ack", 8'h00, {7'h00, ack});
    rc(TWB_ADDR_SR, 8'h70, 8'h30, "sr match");
    rc(TWB_ADDR_IRQST, 8'h10, 8'h10, "irq match");
    chk("irq out", 8'h01, {7'h00, o_irq});
    wr(TWB_ADDR_IRQST, 8'hFF);
    chk("irq clear", 8'h00, {7'h00, o_irq});
    u_peer.xfer(8'h3C, q, ack);
    chk("ack0", 8'h00, {7'h00, ack});
    rc(TWB_ADDR_DATA, 8'hFF, 8'h3C, "rx data");
    wr(TWB_ADDR_CCR, 8'h20);  // Only the ack data bit: legal mid-transfer
    u_peer.xfer(8'hC3, q, ack);
    chk("ack_data_bit nack", 8'h01, {7'h00, ack});
    wr(TWB_ADDR_CCR, 8'h00);
    u_peer.xfer(8'h5A, q, ack);
    chk("ack_data_bit back", 8'h00, {7'h00, ack});
    wr(TWB_ADDR_CCR, 8'h01);  // Divider change resets the clock circuit
    u_peer.xfer(8'hA5, q, ack);
    chk("cks skip", 8'h01, {7'h00, ack});
    wr(TWB_ADDR_CCR, 8'h00);
    u_peer.stop();
    u_peer.start();
    u_peer.xfer(8'h56, q, ack);
    chk("miss ack", 8'h01, {7'h00, ack});
    rc(TWB_ADDR_SR, 8'h10, 8'h00, "sr miss");
    u_peer.stop();
    $display("done write");
  endtask : t_write
  task automatic t_read();
    wr(TWB_ADDR_IRQST, 8'hFF);
    wr(TWB_ADDR_DATA, 8'hA5);
    u_peer.start();
    u_peer.xfer(8'h55, q, ack);
    rc(TWB_ADDR_SR, 8'h40, 8'h40, "trs set");
    rc(TWB_ADDR_CR0, 8'h07, 8'h00, "bc addr");
    u_peer.xfer(8'hFF, q, ack);
    chk("tx data", 8'hA5, q);
    rc(TWB_ADDR_SR, 8'h40, 8'h00, "trs nack");
    rc(TWB_ADDR_CR0, 8'h07, 8'h00, "bc nack");
    rc(TWB_ADDR_IRQST, 8'h08, 8'h08, "irq nack");
    u_peer.stop();
    $display("done read");
  endtask : t_read
  task automatic t_timeout();
    wr(TWB_ADDR_IRQST, 8'hFF);
    wr(TWB_ADDR_CR0, 8'h98);  // Short period first
    u_peer.start();
    u_peer.float_clk();
    repeat (4000) @(posedge i_ref_clk);
    rc(TWB_ADDR_IRQST, 8'h02, 8'h00, "short early");
    repeat (150) @(posedge i_ref_clk);
    rc(TWB_ADDR_IRQST, 8'h02, 8'h02, "short fired");
    u_peer.stop();
    wr(TWB_ADDR_IRQST, 8'hFF);
    wr(TWB_ADDR_CR0, 8'h90);  // Long period must outlast the short one
    u_peer.start();
    u_peer.float_clk();
    repeat (4200) @(posedge i_ref_clk);
    rc(TWB_ADDR_IRQST, 8'h02, 8'h00, "to early");
    repeat (1900) @(posedge i_ref_clk);
    rc(TWB_ADDR_IRQST, 8'h02, 8'h02, "to fired");
    wr(TWB_ADDR_IRQMK, 8'h00);
    chk("irq masked", 8'h00, {7'h00, o_irq});
    u_peer.stop();
    $display("done timeout");
  endtask : t_timeout
  // Master sends all ones while the peer holds data low: arbitration is lost
  task automatic t_master();
    wr(TWB_ADDR_IRQST, 8'hFF);
    wr(TWB_ADDR_DATA, 8'hFF);
    wr(TWB_ADDR_SR, 8'h80);
    repeat (125) @(posedge i_ref_clk);
    u_peer.pull_sda();
    repeat (140) @(posedge i_ref_clk);
    rc(TWB_ADDR_SR, 8'hE0, 8'h20, "arb sr");
    rc(TWB_ADDR_IRQST, 8'h04, 8'h04, "arb irq");
    rc(TWB_ADDR_CR0, 8'h07, 8'h00, "bc arb");
    chk("arb oe", 8'h00, {6'h00, o_pin_oe});
    u_peer.stop();
    $display("done master");
  endtask : t_master
  task automatic t_disable();
    u_peer.start();
    u_peer.xfer(8'h54, q, ack);
    wr(TWB_ADDR_CR0, 8'h00);
    rc(TWB_ADDR_SR, 8'hF0, 8'h00, "sr off");
    chk("oe off", 8'h00, {6'h00, o_pin_oe});
    chk("pin low", 8'h00, {6'h00, o_pin});
    u_peer.stop();
    $display("done disable");
  endtask : t_disable
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // Watchdog: a hang counts as a mismatch
  initial begin
    #1000000;
    fail_count++;
    $display("BAD watchdog exp done got hang");
    summarize();
  end
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    t_reset();
    t_write();
    t_read();
    t_timeout();
    t_master();
    t_disable();
    summarize();
  end
endmodule : testbench
